// ==== common/csrs_pkg.sv ====
// constants and encoders for the store, recall and status block
package csrs_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CFG0 = 8'h00;
    localparam logic [7:0] OFF_CFG1 = 8'h04;
    localparam logic [7:0] OFF_CMD = 8'h08;
    localparam logic [7:0] OFF_PARAM = 8'h0C;
    localparam logic [7:0] OFF_STAT0 = 8'h10;
    localparam logic [7:0] OFF_STAT1 = 8'h14;
    localparam logic [7:0] OFF_STAT2 = 8'h18;
    // command word layout and opcodes
    localparam int OP_W = 4;
    localparam int SLOT_W = 8;
    localparam int SIDX_W = 5;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_SLOT_LSB = 8;
    localparam int CMD_TERM_BIT = 16;
    localparam logic [3:0] OP_SUFFIX = 4'h0;
    localparam logic [3:0] OP_SAVE = 4'h1;
    localparam logic [3:0] OP_RECALL = 4'h2;
    localparam logic [3:0] OP_PRESET = 4'h3;
    localparam int SLOT_MAX = 20;
    localparam logic [7:0] SAVE_MIN = 8'h01;
    localparam logic [7:0] SLOT_TOP = 8'h14;
    // parameter check word: kind on top, value below
    localparam int KIND_W = 4;
    localparam int PAR_KIND_LSB = 28;
    localparam int PAR_VAL_W = 28;
    localparam logic [3:0] K_PKDLY_B = 4'h0;
    localparam logic [3:0] K_PKTRG_A = 4'h1;
    localparam logic [3:0] K_PKTRG_B = 4'h2;
    localparam logic [3:0] K_SMEM = 4'h3;
    localparam logic [3:0] K_SETTLE = 4'h4;
    localparam logic [3:0] K_DUTY = 4'h5;
    localparam logic [3:0] K_FREQ = 4'h6;
    localparam logic [3:0] K_RES = 4'h7;
    localparam logic [27:0] PKDLY_MAX = 28'h00FFFFF;
    localparam logic [27:0] PKTRG_MAX = 28'h0000FFF;
    localparam logic [26:0] SMEM_MAX = 27'h000FFFF;
    localparam logic [27:0] SETTLE_MIN = 28'h000000A;
    localparam logic [27:0] SETTLE_MAX = 28'h0002710;
    localparam logic [27:0] DUTY_MIN = 28'h0000001;
    localparam logic [27:0] DUTY_MAX = 28'h001869F;
    localparam logic [27:0] FREQ_MAX = 28'h00186A0;
    localparam logic [27:0] RES_MAX = 28'h0000003;
    // error codes, two decimal digits
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_RECALL = 8'h54;
    localparam logic [7:0] ERR_STORE = 8'h55;
    localparam logic [7:0] ERR_PKDLY_B = 8'h73;
    localparam logic [7:0] ERR_PKTRG_A = 8'h74;
    localparam logic [7:0] ERR_PKTRG_B = 8'h75;
    localparam logic [7:0] ERR_SMEM = 8'h76;
    localparam logic [7:0] ERR_NOSENS_A = 8'h77;
    localparam logic [7:0] ERR_NOSENS_B = 8'h78;
    localparam logic [7:0] ERR_SETTLE = 8'h79;
    localparam logic [7:0] ERR_DUTY = 8'h81;
    localparam logic [7:0] ERR_FREQ = 8'h82;
    localparam logic [7:0] ERR_RES = 8'h85;
    localparam logic [7:0] ERR_DATA = 8'h90;
    localparam logic [7:0] ERR_CODE = 8'h91;
    // configuration word 0 fields
    localparam int MODE_W = 5;
    localparam int RNG_W = 3;
    localparam int FIL_W = 4;
    localparam int TWO_W = 2;
    localparam int CF_MODE_LSB = 0;
    localparam int CF_RA_LSB = 5;
    localparam int CF_RA_AUTO = 8;
    localparam int CF_RB_LSB = 9;
    localparam int CF_RB_AUTO = 12;
    localparam int CF_FA_LSB = 13;
    localparam int CF_FA_AUTO = 17;
    localparam int CF_FB_LSB = 18;
    localparam int CF_FB_AUTO = 22;
    localparam int CF_UNIT_LSB = 23;
    localparam int CF_CHAN = 25;
    localparam int CF_CAL = 26;
    localparam int CF_REL = 27;
    localparam int CF_HOLD = 28;
    localparam int CF_GT_LSB = 29;
    localparam int CF_LIMCHK = 31;
    // configuration word 1 fields
    localparam int C1_W = 6;
    localparam int C1_OFS = 0;
    localparam int C1_DUTY = 1;
    localparam int C1_LT_LSB = 2;
    localparam int C1_LB_LSB = 4;
    localparam int CFG_W = 38;
    // limits of configuration fields and preset values
    localparam logic [4:0] MODE_MAX = 5'h0D;
    localparam logic [2:0] RANGE_MAX = 3'h5;
    localparam logic [3:0] FILT_MAX = 4'h9;
    localparam logic [1:0] TWO_BAD = 2'h3;
    localparam logic [31:0] CFG0_RST = 32'h00421320;
    localparam logic [5:0] CFG1_RST = 6'h00;
    localparam logic [3:0] CHAN_A = 4'hA;
    localparam logic [3:0] CHAN_B = 4'hB;

    // value below 20 as two decimal digits
    function automatic logic [7:0] two_dig(input logic [4:0] v);
        logic [4:0] lo;
        lo = (v >= 5'h0A) ? v - 5'h0A : v;
        two_dig = {3'h0, (v >= 5'h0A), lo[3:0]};
    endfunction : two_dig

    // mode index to status code
    function automatic logic [7:0] mode_code(input logic [4:0] idx);
        case (idx)
            5'h0C: mode_code = 8'h20;
            5'h0D: mode_code = 8'h21;
            default: mode_code = two_dig(idx);
        endcase
    endfunction : mode_code
endpackage : csrs_pkg

// ==== core/csrs_top.sv ====
// bus slave with configuration slots, parameter checks and status
`timescale 1ns/1ps
module csrs_top
    import csrs_pkg::*;
(
    // clock and reset
    input wire logic I_MCLK,
    input wire logic I_RESET_N,
    // ahb-lite slave
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic O_HREADYOUT,
    output logic [31:0] O_HRDATA,
    output logic O_HRESP,
    // sensor presence
    input wire logic I_SENS_A_PRESENT,
    input wire logic I_SENS_B_PRESENT
);

    logic rst_s1_r;
    logic rst_n;
    logic acc;
    logic acc_ok;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic wr_cfg0;
    logic wr_cfg1;
    logic wr_cmd;
    logic wr_param;
    logic rd_stat0;
    logic [31:0] rd_data;
    logic [31:0] cfg0_r;
    logic [C1_W-1:0] cfg1_r;
    logic [CFG_W-1:0] cfg_word;
    logic [CFG_W-1:0] slot_mem_r [0:SLOT_MAX];
    logic [CFG_W-1:0] rc_word;
    logic [OP_W-1:0] pend_op_r;
    logic [SLOT_W-1:0] pend_slot_r;
    logic [OP_W-1:0] cmd_op;
    logic [SLOT_W-1:0] cmd_slot;
    logic cmd_term;
    logic [OP_W-1:0] ex_op;
    logic [SLOT_W-1:0] ex_slot;
    logic [SIDX_W-1:0] ex_idx;
    logic do_save;
    logic do_recall;
    logic do_preset;
    logic [KIND_W-1:0] par_kind;
    logic [PAR_VAL_W-1:0] par_val;
    logic cfg0_bad;
    logic cfg1_bad;
    logic err_set;
    logic [7:0] err_code;
    logic [7:0] err_r;
    logic [31:0] st0;
    logic [31:0] st1;
    logic [31:0] st2;

    // reset release through two flops
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    // address phase decode
    assign acc = I_HSEL & I_HREADY & I_HTRANS[1];
    assign acc_ok = (I_HADDR[31:8] == 24'h000000) & (I_HSIZE == 3'h2);
    assign rd_stat0 = acc & ~I_HWRITE & acc_ok
        & (I_HADDR[7:0] == OFF_STAT0);

    // write data phase strobes, one per writable register
    assign wr_cfg0 = wr_pend_r & (wr_addr_r == OFF_CFG0);
    assign wr_cfg1 = wr_pend_r & (wr_addr_r == OFF_CFG1);
    assign wr_cmd = wr_pend_r & (wr_addr_r == OFF_CMD);
    assign wr_param = wr_pend_r & (wr_addr_r == OFF_PARAM);

    // write capture and one wait state so writes land before next read
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            O_HREADYOUT <= 1'b1;
        end else begin
            wr_pend_r <= acc & I_HWRITE & acc_ok;
            wr_addr_r <= I_HADDR[7:0];
            O_HREADYOUT <= ~(acc & I_HWRITE);
        end
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        rd_data = 32'h00000000;
        if (acc_ok) begin
            case (I_HADDR[7:0])
                OFF_CFG0: rd_data = cfg0_r;
                OFF_CFG1: rd_data = {26'h0000000, cfg1_r};
                OFF_CMD: rd_data = {16'h0000, pend_slot_r, 4'h0, pend_op_r};
                OFF_STAT0: rd_data = st0;
                OFF_STAT1: rd_data = st1;
                OFF_STAT2: rd_data = st2;
                default: rd_data = 32'h00000000;
            endcase
        end
    end

    // read data captured in the address phase, response always okay
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            O_HRDATA <= 32'h00000000;
            O_HRESP <= 1'b0;
        end else begin
            O_HRESP <= 1'b0;
            if (acc & ~I_HWRITE) begin
                O_HRDATA <= rd_data;
            end
        end
    end

    // field checks of configuration writes
    always_comb begin
        cfg0_bad = (I_HWDATA[CF_MODE_LSB +: MODE_W] > MODE_MAX)
            | (I_HWDATA[CF_RA_LSB +: RNG_W] == 3'h0)
            | (I_HWDATA[CF_RA_LSB +: RNG_W] > RANGE_MAX)
            | (I_HWDATA[CF_RB_LSB +: RNG_W] == 3'h0)
            | (I_HWDATA[CF_RB_LSB +: RNG_W] > RANGE_MAX)
            | (I_HWDATA[CF_FA_LSB +: FIL_W] > FILT_MAX)
            | (I_HWDATA[CF_FB_LSB +: FIL_W] > FILT_MAX)
            | (I_HWDATA[CF_GT_LSB +: TWO_W] == TWO_BAD);
        cfg1_bad = (I_HWDATA[C1_LT_LSB +: TWO_W] == TWO_BAD)
            | (I_HWDATA[C1_LB_LSB +: TWO_W] == TWO_BAD);
    end

    // command decode, slot checks and parameter range checks
    always_comb begin
        cmd_op = I_HWDATA[CMD_OP_LSB +: OP_W];
        cmd_slot = I_HWDATA[CMD_SLOT_LSB +: SLOT_W];
        cmd_term = I_HWDATA[CMD_TERM_BIT];
        par_kind = I_HWDATA[PAR_KIND_LSB +: KIND_W];
        par_val = I_HWDATA[PAR_VAL_W-1:0];
        ex_op = (cmd_op == OP_SUFFIX) ? pend_op_r : cmd_op;
        ex_slot = (cmd_op == OP_SUFFIX) ? pend_slot_r : cmd_slot;
        ex_idx = ex_slot[SIDX_W-1:0];
        do_save = 1'b0;
        do_recall = 1'b0;
        do_preset = 1'b0;
        err_set = 1'b0;
        err_code = ERR_NONE;
        if (wr_cmd && (cmd_op > OP_PRESET)) begin
            err_set = 1'b1;
            err_code = ERR_CODE;
        end else if (wr_cmd && cmd_term) begin
            case (ex_op)
                OP_SAVE: begin
                    if (ex_slot >= SAVE_MIN && ex_slot <= SLOT_TOP) begin
                        do_save = 1'b1;
                    end else begin
                        err_set = 1'b1;
                        err_code = ERR_STORE;
                    end
                end
                OP_RECALL: begin
                    if (ex_slot <= SLOT_TOP) begin
                        do_recall = 1'b1;
                    end else begin
                        err_set = 1'b1;
                        err_code = ERR_RECALL;
                    end
                end
                OP_PRESET: do_preset = 1'b1;
                default: do_preset = 1'b0;
            endcase
        end
        if (wr_param) begin
            case (par_kind)
                K_PKDLY_B: begin
                    err_set = (par_val > PKDLY_MAX);
                    err_code = ERR_PKDLY_B;
                end
                K_PKTRG_A: begin
                    err_set = (par_val > PKTRG_MAX);
                    err_code = ERR_PKTRG_A;
                end
                K_PKTRG_B: begin
                    err_set = (par_val > PKTRG_MAX);
                    err_code = ERR_PKTRG_B;
                end
                K_SMEM: begin
                    // missing sensor takes precedence over data fault
                    err_set = 1'b1;
                    if (!par_val[0] && !I_SENS_A_PRESENT) begin
                        err_code = ERR_NOSENS_A;
                    end else if (par_val[0] && !I_SENS_B_PRESENT) begin
                        err_code = ERR_NOSENS_B;
                    end else begin
                        err_set = (par_val[PAR_VAL_W-1:1] > SMEM_MAX);
                        err_code = ERR_SMEM;
                    end
                end
                K_SETTLE: begin
                    err_set = (par_val < SETTLE_MIN)
                        | (par_val > SETTLE_MAX);
                    err_code = ERR_SETTLE;
                end
                K_DUTY: begin
                    err_set = (par_val < DUTY_MIN)
                        | (par_val > DUTY_MAX);
                    err_code = ERR_DUTY;
                end
                K_FREQ: begin
                    err_set = (par_val > FREQ_MAX);
                    err_code = ERR_FREQ;
                end
                K_RES: begin
                    err_set = (par_val > RES_MAX);
                    err_code = ERR_RES;
                end
                default: begin
                    err_set = 1'b1;
                    err_code = ERR_CODE;
                end
            endcase
        end
        if ((wr_cfg0 && cfg0_bad) || (wr_cfg1 && cfg1_bad)) begin
            err_set = 1'b1;
            err_code = ERR_DATA;
        end
    end

    // pending command held until its terminator
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            pend_op_r <= OP_SUFFIX;
            pend_slot_r <= 8'h00;
        end else if (wr_cmd) begin
            if (cmd_term) begin
                pend_op_r <= OP_SUFFIX;
            end else if (cmd_op != OP_SUFFIX && cmd_op <= OP_PRESET) begin
                pend_op_r <= cmd_op;
                pend_slot_r <= cmd_slot;
            end
        end
    end

    assign cfg_word = {cfg1_r, cfg0_r};
    assign rc_word = slot_mem_r[ex_idx];

    // current configuration: bus writes, recall, preset
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            cfg0_r <= CFG0_RST;
            cfg1_r <= CFG1_RST;
        end else if (do_recall) begin
            cfg1_r <= rc_word[CFG_W-1:32];
            cfg0_r <= rc_word[31:0];
        end else if (do_preset) begin
            cfg0_r <= CFG0_RST;
            cfg1_r <= CFG1_RST;
        end else if (wr_cfg0 && !cfg0_bad) begin
            cfg0_r <= I_HWDATA;
        end else if (wr_cfg1 && !cfg1_bad) begin
            cfg1_r <= I_HWDATA[C1_W-1:0];
        end
    end

    // storage slots; slot 0 keeps the state before a preset
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i <= SLOT_MAX; i++) begin
                slot_mem_r[i] <= {CFG1_RST, CFG0_RST};
            end
        end else if (do_save) begin
            slot_mem_r[ex_idx] <= cfg_word;
        end else if (do_preset) begin
            slot_mem_r[0] <= cfg_word;
        end
    end

    // last error, cleared by status read, new error wins
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            err_r <= ERR_NONE;
        end else if (err_set) begin
            err_r <= err_code;
        end else if (rd_stat0) begin
            err_r <= ERR_NONE;
        end
    end

    // status word 0: error, mode, range a, range b
    always_comb begin
        st0[31:24] = err_r;
        st0[23:16] = mode_code(cfg0_r[CF_MODE_LSB +: MODE_W]);
        st0[15:8] = two_dig(cfg0_r[CF_RA_AUTO] ?
            {2'h0, cfg0_r[CF_RA_LSB +: RNG_W]} + 5'h0A :
            {2'h0, cfg0_r[CF_RA_LSB +: RNG_W]});
        st0[7:0] = two_dig(cfg0_r[CF_RB_AUTO] ?
            {2'h0, cfg0_r[CF_RB_LSB +: RNG_W]} + 5'h0A :
            {2'h0, cfg0_r[CF_RB_LSB +: RNG_W]});
    end

    // status word 1: filters, units, channel, calibrator, relative
    always_comb begin
        st1[31:24] = two_dig(cfg0_r[CF_FA_AUTO] ?
            {1'b0, cfg0_r[CF_FA_LSB +: FIL_W]} + 5'h0A :
            {1'b0, cfg0_r[CF_FA_LSB +: FIL_W]});
        st1[23:16] = two_dig(cfg0_r[CF_FB_AUTO] ?
            {1'b0, cfg0_r[CF_FB_LSB +: FIL_W]} + 5'h0A :
            {1'b0, cfg0_r[CF_FB_LSB +: FIL_W]});
        st1[15:12] = {3'h0, cfg0_r[CF_UNIT_LSB]};
        st1[11:8] = cfg0_r[CF_CHAN] ? CHAN_B : CHAN_A;
        st1[7:4] = {3'h0, cfg0_r[CF_CAL]};
        st1[3:0] = {3'h0, cfg0_r[CF_REL]};
    end

    // status word 2: trigger, group trigger, limits, offset, duty, units
    always_comb begin
        st2[31:28] = {3'h0, cfg0_r[CF_HOLD]};
        st2[27:24] = {2'h0, cfg0_r[CF_GT_LSB +: TWO_W]};
        st2[23:20] = {3'h0, cfg0_r[CF_LIMCHK]};
        st2[19:16] = {2'h0, cfg1_r[C1_LT_LSB +: TWO_W]};
        st2[15:12] = {2'h0, cfg1_r[C1_LB_LSB +: TWO_W]};
        st2[11:8] = {3'h0, cfg1_r[C1_OFS]};
        st2[7:4] = {3'h0, cfg1_r[C1_DUTY]};
        st2[3:0] = {2'h0, cfg0_r[CF_UNIT_LSB +: TWO_W]};
    end

    // checks
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!rst_n);

    save_copy_a: assert property (do_save |=>
        slot_mem_r[$past(ex_idx)] == $past(cfg_word))
        else $error("save did not copy configuration");
    recall_load_a: assert property (do_recall |=>
        cfg_word == $past(rc_word))
        else $error("recall did not load slot");
    no_term_a: assert property (wr_cmd && !cmd_term |=>
        $stable(cfg_word) ##1 $stable(cfg_word))
        else $error("command acted without terminator");
    preset_keep_a: assert property (do_preset |=>
        slot_mem_r[0] == $past(cfg_word) && cfg0_r == CFG0_RST)
        else $error("preset lost previous state");
    save_range_a: assert property (wr_cmd && cmd_term
        && ex_op == OP_SAVE && (ex_slot == 8'h00 || ex_slot > SLOT_TOP)
        |=> err_r == ERR_STORE && $stable(slot_mem_r[0]))
        else $error("bad save slot not flagged");
    recall_range_a: assert property (wr_cmd && cmd_term
        && ex_op == OP_RECALL && ex_slot > SLOT_TOP
        |=> err_r == ERR_RECALL && $stable(cfg_word))
        else $error("bad recall slot not flagged");
    duty_err_a: assert property (wr_param && par_kind == K_DUTY
        && (par_val == 28'h0000000 || par_val == 28'h00186A0)
        |=> err_r == ERR_DUTY)
        else $error("duty range error missed");
    freq_err_a: assert property (wr_param && par_kind == K_FREQ
        |=> err_r == (($past(par_val) > 28'h00186A0) ? ERR_FREQ
        : $past(err_r)))
        else $error("frequency check wrong");
    unk_code_a: assert property (wr_cmd && cmd_op > OP_PRESET
        |=> err_r == ERR_CODE)
        else $error("unknown command not flagged");
    err_clear_a: assert property (rd_stat0 && !err_set
        |=> err_r == ERR_NONE ##1 (err_r == ERR_NONE || $past(err_set)))
        else $error("error code not cleared by read");
    range_code_a: assert property (cfg0_r[CF_RA_AUTO]
        |-> st0[15:12] == 4'h1 && st0[11:8] == {1'b0,
        cfg0_r[CF_RA_LSB +: RNG_W]})
        else $error("auto range code wrong");
    mode_code_a: assert property (
        cfg0_r[CF_MODE_LSB +: MODE_W] == 5'h0C |-> st0[23:16] == 8'h20)
        else $error("peak a delay mode code wrong");
    write_wait_a: assert property (acc && I_HWRITE
        |=> !O_HREADYOUT ##1 O_HREADYOUT)
        else $error("write wait state wrong");

endmodule : csrs_top

// ==== verif/config_store_recall_status_tb_top.sv ====
// self-checking bench for the store, recall and status block
`timescale 1ns/1ps
module config_store_recall_status_tb_top
    import csrs_pkg::*;
;
    logic clk, rst_n, sa, sb, hwrite;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, q, c0, c1;
    wire logic hready, hresp;
    wire logic [31:0] hrdata;
    int errors;
    int compares;

    csrs_top csrs_top_inst (.I_MCLK(clk), .I_RESET_N(rst_n), .I_HSEL(1'b1),
        .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
        .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
        .O_HREADYOUT(hready), .O_HRDATA(hrdata), .O_HRESP(hresp),
        .I_SENS_A_PRESENT(sa), .I_SENS_B_PRESENT(sb));
    csrs_host host_inst (.clk(clk), .hready(hready), .hrdata(hrdata),
        .htrans(htrans), .hwrite(hwrite), .haddr(haddr), .hwdata(hwdata));

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, exp, input string what);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // two decimal digits of a small value
    function automatic logic [7:0] dec(input int v);
        dec = 8'((v / 10) * 16 + v % 10);
    endfunction : dec

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        host_inst.xfer(1'b0, {24'h0, a}, 32'h0, d);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        host_inst.xfer(1'b1, {24'h0, a}, d, x);
    endtask : wr

    // status words expected for a configuration with no error pending
    task automatic chk_stat(input logic [31:0] c, input logic [5:0] k);
        logic [31:0] s;
        logic [7:0] m;
        m = (c[4:0] > 5'h0B) ? {7'h10, c[0]} : dec(c[4:0]);
        rd(OFF_STAT0, s);
        chk(s, {8'h00, m, dec(c[7:5] + 10 * c[8]),
            dec(c[11:9] + 10 * c[12])}, "stat0");
        rd(OFF_STAT1, s);
        chk(s, {dec(c[16:13] + 10 * c[17]),
            dec(c[21:18] + 10 * c[22]), 3'h0, c[23],
            c[25] ? 4'hB : 4'hA, 3'h0, c[26], 3'h0, c[27]}, "stat1");
        rd(OFF_STAT2, s);
        chk(s, {3'h0, c[28], 2'h0, c[30:29], 3'h0, c[31],
            2'h0, k[3:2], 2'h0, k[5:4], 3'h0, k[0], 3'h0, k[1],
            2'h0, c[24:23]}, "stat2");
    endtask : chk_stat

    // one error shows once, then the next read sees none
    task automatic chk_err(input logic [7:0] a, input logic [31:0] d,
                           input logic [7:0] e);
        logic [31:0] s;
        wr(a, d);
        rd(OFF_STAT0, s);
        chk({24'h0, s[31:24]}, {24'h0, e}, "error");
        chk({31'h0, hresp}, 32'h0, "hresp");
        rd(OFF_STAT0, s);
        chk({24'h0, s[31:24]}, 32'h0, "cleared");
    endtask : chk_err

    task automatic print_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    // cut a hang short
    initial begin
        #500000;
        errors++;
        print_verdict();
    end

    // main sequence
    initial begin
        errors = 0;
        compares = 0;
        rst_n = 1'b0;
        sa = 1'b1;
        sb = 1'b1;
        void'($urandom(32'h2334));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        wr(8'h1C, 32'hFFFFFFFF);
        rd(8'h1C, q);
        chk(q, 32'h0, "unmapped");
        chk_stat(CFG0_RST, 6'h0);
        $display("test reset done");
        for (int i = 0; i < 28; i++) begin
            c0 = $urandom;
            c0[4:0] = 5'(i % 14);
            c0[7:5] = 3'(1 + $urandom % 5);
            c0[11:9] = 3'(1 + $urandom % 5);
            c0[16:13] = 4'($urandom % 10);
            c0[21:18] = 4'($urandom % 10);
            c0[30:29] = 2'($urandom % 3);
            c1 = {26'h0, 2'($urandom % 3), 2'($urandom % 3), 2'($urandom)};
            sa <= 1'($urandom);
            sb <= 1'($urandom);
            wr(OFF_CFG0, c0);
            wr(OFF_CFG1, c1);
            rd(OFF_CFG0, q);
            chk(q, c0, "cfg0");
            chk_stat(c0, c1[5:0]);
        end
        $display("test status fields done");
        host_inst.cmd(OP_SAVE, 8'h14, 1'b1);
        wr(OFF_CFG0, CFG0_RST);
        wr(OFF_CFG1, 32'h0);
        host_inst.cmd(OP_RECALL, 8'h14, 1'b0);
        rd(OFF_CFG0, q);
        chk(q, CFG0_RST, "pending");
        rd(OFF_CMD, q);
        chk(q, {16'h0, 8'h14, 4'h0, OP_RECALL}, "pending cmd");
        host_inst.cmd(OP_SUFFIX, 8'h00, 1'b1);
        rd(OFF_CFG0, q);
        chk(q, c0, "recall");
        rd(OFF_CFG1, q);
        chk(q, c1, "recall cfg1");
        host_inst.cmd(OP_PRESET, 8'h00, 1'b1);
        rd(OFF_CFG0, q);
        chk(q, CFG0_RST, "preset");
        host_inst.cmd(OP_RECALL, 8'h00, 1'b1);
        rd(OFF_CFG0, q);
        chk(q, c0, "slot0");
        rd(OFF_CFG1, q);
        chk(q, c1, "slot0 cfg1");
        $display("test store recall done");
        sa <= 1'b1;
        sb <= 1'b1;
        chk_err(OFF_CMD, 32'h00010101, 8'h00);
        chk_err(OFF_CMD, 32'h00010001, 8'h55);
        chk_err(OFF_CMD, 32'h00011501, 8'h55);
        chk_err(OFF_CMD, 32'h00011502, 8'h54);
        chk_err(OFF_CMD, 32'h00010004, 8'h91);
        chk_err(OFF_CFG0, 32'h0042132E, 8'h90);
        chk_err(OFF_PARAM, 32'h00100000, 8'h73);
        chk_err(OFF_PARAM, 32'h10001000, 8'h74);
        chk_err(OFF_PARAM, 32'h20001000, 8'h75);
        chk_err(OFF_PARAM, 32'h30020000, 8'h76);
        sa <= 1'b0;
        chk_err(OFF_PARAM, 32'h30000000, 8'h77);
        sb <= 1'b0;
        chk_err(OFF_PARAM, 32'h30000001, 8'h78);
        chk_err(OFF_PARAM, 32'h40000009, 8'h79);
        chk_err(OFF_PARAM, 32'h40002711, 8'h79);
        chk_err(OFF_PARAM, 32'h4000000A, 8'h00);
        chk_err(OFF_PARAM, 32'h50000000, 8'h81);
        chk_err(OFF_PARAM, 32'h500186A0, 8'h81);
        chk_err(OFF_PARAM, 32'h600186A1, 8'h82);
        chk_err(OFF_PARAM, 32'h600186A0, 8'h00);
        chk_err(OFF_PARAM, 32'h70000004, 8'h85);
        chk_err(OFF_PARAM, 32'h70000003, 8'h00);
        chk_err(OFF_PARAM, 32'h80000000, 8'h91);
        $display("test error codes done");
        print_verdict();
    end
endmodule : config_store_recall_status_tb_top

// ==== verif/csrs_host.sv ====
// host controller model that drives the register bus
`timescale 1ns/1ps
module csrs_host
    import csrs_pkg::*;
(
    // bus side
    input wire logic clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [31:0] haddr,
    output logic [31:0] hwdata
);
    // bus idle at time zero
    initial begin
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
    end

    // one word transfer; ready judged before each edge to avoid races
    task automatic xfer(input logic w, input logic [31:0] a, d,
                        output logic [31:0] q);
        logic r;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do begin
            @(negedge clk);
            r = hready;
            @(posedge clk);
        end while (r !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(negedge clk);
            r = hready;
            q = hrdata;
            @(posedge clk);
        end while (r !== 1'b1);
    endtask : xfer

    // save, recall, preset or bare suffix; slot sent whole
    task automatic cmd(input logic [3:0] op, input logic [7:0] slot,
                       input logic term);
        logic [31:0] q;
        xfer(1'b1, {24'h0, OFF_CMD}, {15'h0, term, slot, 4'h0, op}, q);
    endtask : cmd
endmodule : csrs_host
